// >>> verilog/rtccsr_pkg.sv
// rtccsr_pkg: offsets, field layouts, reset values and timing of the
// rtc control/status register bank.
// assumes a 100 MHz clk and a host register port given by the serial engine.
package rtccsr_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CNT0 = 8'h04;
  localparam logic [7:0] ADDR_CNT2 = 8'h06;
  localparam logic [7:0] ADDR_CTRL = 8'h07;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CHG = 8'h10;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h06;
  localparam logic [7:0] CHG_RST = 8'h00;
  // field positions and codes
  localparam int STAT_OSF_BIT = 7;
  localparam int STAT_AF_BIT = 0;
  localparam logic [3:0] CHG_UNLOCK = 4'hA;
  localparam logic [1:0] DS_NONE = 2'h1;
  localparam logic [1:0] DS_ONE = 2'h2;
  localparam logic [1:0] RS_OFF = 2'h0;
  // timing: base tick at 65.536 kHz drives a 16-bit divider
  localparam int CLK_NS = 10;
  localparam int BASE_TICK_NS = 15258;
  localparam int BASE_CYC = BASE_TICK_NS / CLK_NS;
  localparam int PULSE_MS = 250;
  localparam int PULSE_CYC_DEF = PULSE_MS * 1000000 / CLK_NS;
  localparam logic [3:0] DIV_4096_WRAP = 4'hF;
  localparam logic [15:0] DIV_1HZ_WRAP = 16'hFFFF;

  typedef struct packed {
    logic osc_disable;
    logic countdown_enable;
    logic countdown_mode_select;
    logic backup_wave_enable;
    logic reset_steer;
    logic [1:0] wave_rate_select;
    logic alarm_irq_enable;
  } rtccsr_ctrl_s;

  typedef struct packed {
    logic [3:0] charge_unlock_pattern;
    logic [1:0] diode_select;
    logic [1:0] resistor_select;
  } rtccsr_chg_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtccsr_req_s;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } rtccsr_rsp_s;
endpackage : rtccsr_pkg

// >>> verilog/rtccsr_top.sv
// rtccsr_top: control, status and charge registers plus the watchdog/alarm
// down counter, square-wave divider and pulse outputs of a serial rtc.
// assumes the serial engine presents one-cycle requests on req and that
// on_backup comes asynchronously from the power monitor.
// Operation
// - oscillator stops and standby entered when osc_disable set on backup supply.
// - on main supply the oscillator always runs.
// - countdown_enable starts counting; cleared, the 24 bits are plain storage.
// - mode 0 decrements each second, reloads seed at zero, keeps going.
// - mode 1 decrements every 1/4096 s, sets alarm_flag at zero, stops until its pulse ends (with no pulse, until a counter access), then reloads seed.
// - watchdog mode: any counter byte access reloads seed and restarts.
// - backup_wave_enable keeps square wave on backup; else pin floats.
// - watchdog expiry gives 250 ms low pulse on reset pin with reset_steer clear, on irq with reset_steer and alarm_irq_enable, else none.
// - wave_rate_select picks 1 Hz, 4.096, 8.192 or 32.768 kHz.
// - alarm_flag reaches irq only with alarm_irq_enable and reset_steer set.
// - a started 250 ms pulse always runs its full length.
// - power-up clears control bits and sets both rate bits.
// - osc_stopped_flag set whenever oscillator stops; held until host writes 0.
// - alarm_flag set at zero; write 0 clears, write 1 keeps.
// - periodic mode with irq enable and reset_steer holds irq low while alarm_flag set.
// - watchdog irq pulse sets alarm_flag, cleared by hardware at pulse end.
// - charger enabled only by unlock pattern 1010; off at power-up.
// - diode_select 01 no diode, 10 one diode, 00 and 11 disable.
// - resistor_select 01, 10, 11 pick 250, 2k, 4k ohm; 00 disables.
// - an all-zero counter is disabled whatever countdown_enable says.
// - during a reset pulse host access is blocked; at end flag clears.
`timescale 1ns/1ps
module rtccsr_top
  import rtccsr_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_CYC_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire rtccsr_req_s req,
  output rtccsr_rsp_s rsp,
  output logic access_blocked,
  input wire logic on_backup,
  output logic osc_running,
  output logic standby,
  output logic square_wave_out_o,
  output logic square_wave_out_oe,
  output logic reset_out_n_o,
  output logic reset_out_n_oe,
  output logic irq_out_n_o,
  output logic irq_out_n_oe,
  output logic charge_enable,
  output logic charge_diode,
  output logic [1:0] charge_res_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0] bk_sync;
    logic osc_prev;
    logic [15:0] pre;
    logic [15:0] div;
    rtccsr_ctrl_s ctrl;
    logic osc_stopped_flag;
    logic af;
    rtccsr_chg_s chg;
    logic [23:0] cnt;
    logic [23:0] seed;
    logic halted;
    logic [31:0] pcnt;
    logic p_rst;
    logic p_irq;
    rtccsr_rsp_s rsp;
  } rtccsr_state_s;

  rtccsr_state_s st_q;
  rtccsr_state_s st_d;

  // counter byte address decode, shared by read and write paths
  function automatic logic is_cnt_addr(input logic [7:0] a);
    is_cnt_addr = (a >= ADDR_CNT0) && (a <= ADDR_CNT2);
  endfunction : is_cnt_addr

  // square-wave tap on the divider for each rate code
  function automatic logic wave_tap(input logic [1:0] rs, input logic [15:0] d);
    case (rs)
      2'h0: wave_tap = d[15];
      2'h1: wave_tap = d[3];
      2'h2: wave_tap = d[2];
      default: wave_tap = d[0];
    endcase
  endfunction : wave_tap

  ////////////////////////////////////////////////////////////////////////////
  // derived terms

  logic backup;
  logic osc_run;
  logic tick;
  logic t4096;
  logic t1hz;
  logic dec_tick;
  logic cnt_live;
  logic zero_evt;
  logic acc;
  logic [1:0] byte_ix;
  logic irq_level;

  assign backup = st_q.bk_sync[1];
  assign osc_run = !(backup && st_q.ctrl.osc_disable);
  assign tick = osc_run && (st_q.pre == 16'(BASE_CYC - 1));
  assign t4096 = tick && (st_q.div[3:0] == DIV_4096_WRAP);
  assign t1hz = tick && (st_q.div == DIV_1HZ_WRAP);
  assign dec_tick = st_q.ctrl.countdown_mode_select ? t4096 : t1hz;
  // counting needs enable, nonzero seed, not stopped, no pulse running
  assign cnt_live = st_q.ctrl.countdown_enable && (st_q.seed != 24'h0)
                    && !st_q.halted && !st_q.p_rst && !st_q.p_irq;
  assign zero_evt = cnt_live && dec_tick && (st_q.cnt <= 24'h1);
  assign access_blocked = st_q.p_rst;
  assign acc = req.valid && !st_q.p_rst;
  assign byte_ix = 2'(req.addr - ADDR_CNT0);
  // periodic mode level interrupt
  assign irq_level = st_q.af && st_q.ctrl.alarm_irq_enable && st_q.ctrl.reset_steer
                     && !st_q.ctrl.countdown_mode_select;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    st_d.bk_sync = {st_q.bk_sync[0], on_backup};
    st_d.osc_prev = osc_run;
    st_d.rsp.ack = 1'b0;
    // timebase, frozen while the oscillator is stopped
    if (osc_run) begin
      st_d.pre = tick ? 16'h0 : st_q.pre + 16'h1;
      if (tick) begin
        st_d.div = st_q.div + 16'h1;
      end
    end
    // counter decrement
    if (cnt_live && dec_tick) begin
      st_d.cnt = st_q.cnt - 24'h1;
    end
    // host access, refused during a reset pulse
    if (acc) begin
      st_d.rsp.ack = 1'b1;
      st_d.rsp.rdata = 8'h00;
      if (is_cnt_addr(req.addr)) begin
        st_d.rsp.rdata = st_q.cnt[8*byte_ix +: 8];
        if (req.write) begin
          st_d.seed[8*byte_ix +: 8] = req.wdata;
          st_d.cnt = st_q.seed;
          st_d.cnt[8*byte_ix +: 8] = req.wdata;
          st_d.halted = 1'b0;
        end else if (st_q.ctrl.countdown_mode_select) begin
          st_d.cnt = st_q.seed;
          st_d.halted = 1'b0;
        end
      end
      case (req.addr)
        ADDR_CTRL: begin
          st_d.rsp.rdata = st_q.ctrl;
          if (req.write) begin
            st_d.ctrl = req.wdata;
          end
        end
        ADDR_STAT: begin
          st_d.rsp.rdata = 8'h00;
          st_d.rsp.rdata[STAT_OSF_BIT] = st_q.osc_stopped_flag;
          st_d.rsp.rdata[STAT_AF_BIT] = st_q.af;
          if (req.write) begin
            st_d.osc_stopped_flag = st_q.osc_stopped_flag && req.wdata[STAT_OSF_BIT];
            st_d.af = st_q.af && req.wdata[STAT_AF_BIT];
          end
        end
        ADDR_CHG: begin
          st_d.rsp.rdata = st_q.chg;
          if (req.write) begin
            st_d.chg = req.wdata;
          end
        end
        default: begin
        end
      endcase
    end
    // expiry: hardware set wins over a host clear in the same cycle
    if (zero_evt) begin
      st_d.af = 1'b1;
      if (st_q.ctrl.countdown_mode_select) begin
        st_d.cnt = 24'h0;
        st_d.halted = 1'b1;
        st_d.pcnt = 32'(PULSE_CYC - 1);
        st_d.p_rst = !st_q.ctrl.reset_steer;
        st_d.p_irq = st_q.ctrl.reset_steer && st_q.ctrl.alarm_irq_enable;
      end else begin
        st_d.cnt = st_q.seed;
      end
    end
    // pulse timer runs to its end regardless of host writes
    if (st_q.p_rst || st_q.p_irq) begin
      st_d.pcnt = st_q.pcnt - 32'h1;
      if (st_q.pcnt == 32'h0) begin
        st_d.p_rst = 1'b0;
        st_d.p_irq = 1'b0;
        st_d.af = 1'b0;
        st_d.halted = 1'b0;
        st_d.cnt = st_d.seed;
      end
    end
    // oscillator stop marks the flag
    if (st_q.osc_prev && !osc_run) begin
      st_d.osc_stopped_flag = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, power-up values

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.osc_prev <= 1'b1;
      st_q.ctrl <= CTRL_RST;
      st_q.osc_stopped_flag <= 1'b1;
      st_q.chg <= CHG_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  assign rsp = st_q.rsp;
  assign osc_running = osc_run;
  assign standby = !osc_run;
  assign square_wave_out_o = wave_tap(st_q.ctrl.wave_rate_select, st_q.div);
  assign square_wave_out_oe = !backup || st_q.ctrl.backup_wave_enable;
  assign reset_out_n_o = 1'b0;
  assign reset_out_n_oe = st_q.p_rst;
  assign irq_out_n_o = 1'b0;
  assign irq_out_n_oe = st_q.p_irq || irq_level;
  // charger decode
  assign charge_enable = (st_q.chg.charge_unlock_pattern == CHG_UNLOCK)
                         && ((st_q.chg.diode_select == DS_NONE)
                             || (st_q.chg.diode_select == DS_ONE))
                         && (st_q.chg.resistor_select != RS_OFF);
  assign charge_diode = charge_enable && (st_q.chg.diode_select == DS_ONE);
  assign charge_res_sel = charge_enable ? st_q.chg.resistor_select : RS_OFF;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  chk_osf_on_stop: assert property (ce && st_q.osc_prev && !osc_run |=> st_q.osc_stopped_flag)
    else $error("osc stop did not set osc_stopped_flag");
  chk_main_osc_run: assert property (!backup |-> osc_running)
    else $error("oscillator stopped on main supply");
  chk_store_hold: assert property (ce && !st_q.ctrl.countdown_enable && !req.valid
                                   && !st_q.p_rst && !st_q.p_irq |=> $stable(st_q.cnt))
    else $error("counter moved while disabled");
  chk_zero_reload: assert property (ce && zero_evt && !st_q.ctrl.countdown_mode_select
                                    |=> st_q.af && st_q.cnt == $past(st_q.seed))
    else $error("periodic mode did not reload at zero");
  chk_wd_stop: assert property (ce && zero_evt && st_q.ctrl.countdown_mode_select
                                |=> st_q.af && st_q.halted && st_q.cnt == 24'h0)
    else $error("watchdog did not stop at zero");
  chk_af_keep_one: assert property (ce && acc && req.write && req.addr == ADDR_STAT
                                    && !st_q.af && !zero_evt |=> !st_q.af)
    else $error("write of one set alarm_flag");
  chk_irq_gate: assert property (irq_out_n_oe |-> st_q.p_irq
                                 || (st_q.af && st_q.ctrl.alarm_irq_enable && st_q.ctrl.reset_steer))
    else $error("irq driven without enable and steer");
  chk_rst_block: assert property (st_q.p_rst && ce |=> !rsp.ack)
    else $error("access answered during reset pulse");
  chk_pulse_full: assert property ($fell(st_q.p_rst || st_q.p_irq)
                                   |-> $past(st_q.pcnt) == 32'h0 && !st_q.af)
    else $error("pulse ended early or flag left set");
  chk_charge_key: assert property (charge_enable
                                   |-> st_q.chg.charge_unlock_pattern == CHG_UNLOCK)
    else $error("charger on without unlock pattern");
  chk_status_zero: assert property (ce && acc && !req.write && req.addr == ADDR_STAT
                                    |=> rsp.rdata[6:1] == 6'h00)
    else $error("status reserved bits not zero");

  // supply and pin behaviour
  chk_backup_stop: assert property (backup && st_q.ctrl.osc_disable
                                    |-> standby && !osc_running)
    else $error("oscillator kept running on backup with osc_disable set");
  chk_wave_float: assert property (backup && !st_q.ctrl.backup_wave_enable
                                   |-> !square_wave_out_oe)
    else $error("square wave driven on backup without enable");
  chk_ctrl_reset: assert property ($rose(resetn)
                                   |-> st_q.ctrl == CTRL_RST && st_q.osc_stopped_flag && !st_q.af)
    else $error("power-up register values wrong");

  // expiry steering onto the two open-drain pins
  chk_rst_steer: assert property (ce && zero_evt && st_q.ctrl.countdown_mode_select
                                  && !st_q.ctrl.reset_steer
                                  |=> reset_out_n_oe && !reset_out_n_o && access_blocked)
    else $error("watchdog expiry did not pulse the reset pin");
  chk_irq_steer: assert property (ce && zero_evt && st_q.ctrl.countdown_mode_select
                                  && st_q.ctrl.reset_steer && st_q.ctrl.alarm_irq_enable
                                  |=> irq_out_n_oe && !irq_out_n_o && !reset_out_n_oe)
    else $error("watchdog expiry did not pulse the irq pin");
  chk_irq_level: assert property (st_q.af && st_q.ctrl.alarm_irq_enable
                                  && st_q.ctrl.reset_steer && !st_q.ctrl.countdown_mode_select
                                  |-> irq_out_n_oe)
    else $error("periodic alarm level not on irq pin");

  // host side: answers, flag clears and watchdog kick
  chk_ack_next: assert property (ce && acc |=> rsp.ack)
    else $error("taken request not answered");
  chk_af_clear: assert property (ce && acc && req.write && req.addr == ADDR_STAT
                                 && !req.wdata[STAT_AF_BIT] && !zero_evt |=> !st_q.af)
    else $error("write of zero left alarm_flag set");
  chk_osf_clear: assert property (ce && acc && req.write && req.addr == ADDR_STAT
                                  && !req.wdata[STAT_OSF_BIT] && !(st_q.osc_prev && !osc_run)
                                  |=> !st_q.osc_stopped_flag)
    else $error("write of zero left osc_stopped_flag set");
  chk_wd_kick: assert property (ce && acc && !req.write && is_cnt_addr(req.addr)
                                && st_q.ctrl.countdown_mode_select && !zero_evt
                                && !st_q.p_rst && !st_q.p_irq |=> st_q.cnt == $past(st_q.seed))
    else $error("counter read did not reload the watchdog seed");

  // charger decode refuses the disabling codes
  chk_diode_off: assert property ((st_q.chg.diode_select == 2'h0
                                   || st_q.chg.diode_select == 2'h3) |-> !charge_enable)
    else $error("charger on with disabling diode code");
  chk_res_off: assert property (st_q.chg.resistor_select == RS_OFF
                                |-> !charge_enable && charge_res_sel == RS_OFF)
    else $error("charger on with resistor code zero");

  cov_periodic_zero: cover property (ce && zero_evt && !st_q.ctrl.countdown_mode_select);
  cov_wd_kick: cover property (ce && acc && !req.write && is_cnt_addr(req.addr)
                               && st_q.ctrl.countdown_mode_select);
  cov_backup_stop: cover property (standby);
  cov_rst_pulse: cover property ($rose(st_q.p_rst));
  cov_irq_pulse: cover property ($rose(st_q.p_irq));

endmodule : rtccsr_top

// >>> sim/rtccsr_host.sv
// rtccsr_host: host model that issues single register requests.
// assumes the register port of rtccsr_top, requests launched at posedge.
`timescale 1ns/1ps
module rtccsr_host
  import rtccsr_pkg::*;
(
  input wire logic clk,
  output rtccsr_req_s req,
  input wire rtccsr_rsp_s rsp
);
  initial req = '0;
  ////////////////////////////////////////////////////////////////////////////
  // one request, one cycle of valid, then up to two cycles for the ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic ok);
    ok = 1'b0;
    rd = 8'h00;
    @(posedge clk);
    req <= '{1'b1, w, a, d};
    @(posedge clk);
    // released fields show a changing pattern, not the last value
    req <= '{1'b0, ~w, ~a, ~d};
    repeat (2) begin
      @(posedge clk);
      if (!ok && rsp.ack === 1'b1) begin
        ok = 1'b1;
        rd = rsp.rdata;
      end
    end
  endtask : xfer
  // counter accesses by the host in watchdog mode reload the watchdog seed
endmodule : rtccsr_host

// >>> sim/rtc_control_status_regs_tb.sv
// rtc_control_status_regs_tb: scenario tasks for the rtc register bank.
// assumes rtccsr_host as the register master and a short pulse parameter.
`timescale 1ns/1ps
module rtc_control_status_regs_tb
  import rtccsr_pkg::*;
;
  localparam int P = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic on_backup = 1'b0;
  rtccsr_req_s req;
  rtccsr_rsp_s rsp;
  logic blk, osc, stby, sq, sq_oe, rst_oe, irq_oe, ch_en, ch_d;
  logic [1:0] ch_r;
  logic rst_o, irq_o;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  rtccsr_host host (.clk(clk), .req(req), .rsp(rsp));
  rtccsr_top #(.PULSE_CYC(P)) DUT (.clk(clk), .resetn(resetn), .ce(ce), .req(req),
    .rsp(rsp), .access_blocked(blk), .on_backup(on_backup), .osc_running(osc),
    .standby(stby), .square_wave_out_o(sq), .square_wave_out_oe(sq_oe),
    .reset_out_n_o(rst_o), .reset_out_n_oe(rst_oe), .irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe),
    .charge_enable(ch_en), .charge_diode(ch_d), .charge_res_sel(ch_r));
  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rd;
    logic ok;
    host.xfer(1'b1, a, d, rd, ok);
    chk("write ack", 16'h1, {15'h0, ok});
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] rd;
    logic ok;
    host.xfer(1'b0, a, 8'h00, rd, ok);
    chk(n, {8'h01, e}, {7'h0, ok, rd});
  endtask : rdc
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("wait bound", 16'h1, {15'h0, s === v});
  endtask : wait_for
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_and_status();
    rdc("ctrl reset", ADDR_CTRL, CTRL_RST);
    rdc("stat reset", ADDR_STAT, 8'h80);
    rdc("chg reset", ADDR_CHG, CHG_RST);
    chk("chg en reset", 16'h0, {15'h0, ch_en});
    wr(ADDR_STAT, 8'hFF);
    rdc("stat wr ones", ADDR_STAT, 8'h80);
    wr(ADDR_STAT, 8'h00);
    rdc("stat cleared", ADDR_STAT, 8'h00);
    rdc("unmapped", 8'h0B, 8'h00);
  endtask : t_reset_and_status
  task automatic t_charge();
    logic [7:0] tbl[8] = '{8'hA5, 8'hAA, 8'hAB, 8'hA4, 8'hA1, 8'hAD, 8'h55, 8'hB6};
    logic e;
    foreach (tbl[i]) begin
      wr(ADDR_CHG, tbl[i]);
      e = tbl[i][7:4] == CHG_UNLOCK && (tbl[i][3:2] == DS_NONE || tbl[i][3:2] == DS_ONE)
          && tbl[i][1:0] != RS_OFF;
      rdc("chg readback", ADDR_CHG, tbl[i]);
      chk("chg enable", {15'h0, e}, {15'h0, ch_en});
      if (e) begin
        chk("chg diode", {15'h0, tbl[i][3:2] == DS_ONE}, {15'h0, ch_d});
        chk("chg res", {14'h0, tbl[i][1:0]}, {14'h0, ch_r});
      end
    end
  endtask : t_charge
  task automatic t_wave(input logic [1:0] rs, input int sh);
    int n;
    logic s0;
    wr(ADDR_CTRL, {5'h0, rs, 1'b0});
    s0 = sq;
    wait_for(sq, ~s0, 4 * BASE_CYC << sh);
    s0 = sq;
    n = 0;
    while (sq === s0 && n < 4 * BASE_CYC << sh) begin
      @(posedge clk);
      n++;
    end
    chk("half period", 16'(BASE_CYC << sh), 16'(n));
  endtask : t_wave
  task automatic t_backup();
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    @(posedge clk);
    chk("osc on main", 16'h1, {15'h0, osc});
    on_backup <= 1'b1;
    repeat (4) @(posedge clk);
    chk("osc stop", 16'h0001, {7'h0, osc, 7'h0, stby});
    chk("wave float", 16'h0, {15'h0, sq_oe});
    on_backup <= 1'b0;
    repeat (4) @(posedge clk);
    chk("osc back", 16'h1, {15'h0, osc});
    rdc("osf set", ADDR_STAT, 8'h80);
    wr(ADDR_CTRL, 8'h06);
  endtask : t_backup
  task automatic t_pulse(input logic [7:0] ctl, input logic steer);
    int n;
    logic [7:0] rd;
    logic ok;
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_CNT0, 8'h01);
    wr(ADDR_CTRL, ctl);
    if (steer) wait_for(irq_oe, 1'b1, 30000);
    else wait_for(rst_oe, 1'b1, 30000);
    chk("pin steer", {14'h0, steer, ~steer}, {14'h0, irq_oe, rst_oe});
    chk("blocked", {15'h0, ~steer}, {15'h0, blk});
    chk("pin low", 16'h0, {14'h0, rst_o, irq_o});
    // mid-pulse access: refused under reset, aie drop under irq
    host.xfer(1'b1, ADDR_CTRL, ctl & 8'hFE, rd, ok);
    chk("mid ack", {15'h0, steer}, {15'h0, ok});
    n = 4;
    while ((rst_oe === 1'b1 || irq_oe === 1'b1) && n < 4 * P) begin
      @(posedge clk);
      n++;
    end
    chk("pulse len", 16'(P), 16'(n));
    wr(ADDR_CTRL, 8'h06);
    rdc("af cleared", ADDR_STAT, 8'h00);
  endtask : t_pulse
  ////////////////////////////////////////////////////////////////////////////
  // closing report and timeout
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset_and_status();
    t_charge();
    t_wave(2'h3, 0);
    t_wave(2'h2, 2);
    t_backup();
    t_pulse(8'h66, 1'b0);
    t_pulse(8'h6F, 1'b1);
    finish_test();
  end
endmodule : rtc_control_status_regs_tb
